//--- can_ext_pkg.sv
// Purpose: Shared constants and carriers for the dual CAN controller extensions.
// Assumes: One system clock and synchronous reset.
// Notes: Register offsets are byte addresses on the 8-bit register port.
package can_ext_pkg;
    localparam logic [11:0] FILTER0_MATCH_BYTE3 = 12'hB28;
    localparam logic [11:0] FILTER0_IGNORE_BYTE3 = 12'hB29;
    localparam logic [11:0] FILTER0_MATCH_BYTE2 = 12'hB2A;
    localparam logic [11:0] FILTER0_IGNORE_BYTE2 = 12'hB2B;
    localparam logic [11:0] FILTER0_MATCH_BYTE1 = 12'hB2C;
    localparam logic [11:0] FILTER0_IGNORE_BYTE1 = 12'hB2D;
    localparam logic [11:0] FILTER0_MATCH_BYTE0 = 12'hB2E;
    localparam logic [11:0] FILTER0_IGNORE_BYTE0 = 12'hB2F;
    localparam logic [11:0] RELAY_ENABLE_REG = 12'hB05;
    localparam logic [11:0] COMMAND_REG = 12'hB01;
    localparam logic [11:0] TEST_MODE_REG = 12'hB24;
    localparam logic [11:0] DISPATCH_BYTE0 = 12'hB27;
    localparam logic [11:0] DISPATCH_BYTE1 = 12'hB26;
    localparam logic [11:0] DISPATCH_BYTE2 = 12'hB25;
    localparam logic [11:0] DISPATCH_BYTE3 = 12'hB23;
    localparam logic [11:0] STATUS_REG = 12'hB02;
    localparam logic [11:0] CTRL1_DELTA = 12'h200;
    localparam int CMD_TX_REQUEST_BIT = 0;
    localparam int CMD_RELAY_REQUEST_BIT = 6;
    localparam int TEST_SELF_LOOP_BIT = 0;
    localparam int TEST_DUAL_LOOP_BIT = 1;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [6:0] DISPATCH_BIT_MULT = 7'h64;
    localparam int DISPATCH_WIDTH = 28;
    typedef struct packed {
        logic [28:0] ident;
        logic extended;
        logic [1:0] filter_hit;
    } rx_frame_t;
    typedef struct packed {
        logic start;
        logic from_relay;
    } tx_start_t;
endpackage : can_ext_pkg

//--- can_ext_channel.sv
// Purpose: One controller channel: filter, relay flag, dispatch timer and transmit arbitration.
// Assumes: bit_tick pulses once per nominal bit time of this channel's own baud rate.
// Notes: The protocol engine lies outside; it gets start and relay source and returns done, error and received frames.
`timescale 1ns/1ps
`default_nettype none
module can_ext_channel
(
    input wire logic clock,
    input wire logic rst,
    input wire logic bit_tick,
    input wire logic [31:0] match_code,
    input wire logic [31:0] ignore_code,
    input wire logic relay_enable,
    input wire logic [27:0] dispatch_value,
    input wire logic dispatch_written,
    input wire logic rx_valid,
    input wire logic [28:0] rx_ident,
    input wire logic rx_extended,
    input wire logic local_request,
    input wire logic relay_request,
    input wire logic tx_done,
    input wire logic tx_error,
    output logic accepted,
    output logic relay_flag,
    output logic tx_start,
    output logic tx_from_relay,
    output logic tx_busy
);
    logic [34:0] bit_count;
    logic dispatch_pending;
    logic local_pending;
    logic relay_pending;
    logic hit;
    logic dispatch_active;
    logic [31:0] ident_word;
    logic [34:0] dispatch_limit;
    logic dispatch_due;

    assign ident_word = rx_extended ? {3'h0, rx_ident} : {21'h000000, rx_ident[10:0]};
    assign hit = &(~(ident_word ^ match_code) | ignore_code);
    assign dispatch_active = |dispatch_value;
    assign dispatch_limit = 35'(dispatch_value) * 35'(can_ext_pkg::DISPATCH_BIT_MULT);
    // A write restarts the period, so an expiry on that same edge is dropped.
    assign dispatch_due = bit_tick && !dispatch_written && dispatch_active &&
        (bit_count + 35'h1 >= dispatch_limit);

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            accepted <= 1'b0;
            relay_flag <= 1'b0;
        end
        else if (rx_valid)
        begin
            accepted <= hit;
            relay_flag <= hit & relay_enable;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst || dispatch_written || !dispatch_active)
            bit_count <= 35'h0;
        else if (bit_tick)
            bit_count <= (bit_count + 35'h1 >= dispatch_limit) ? 35'h0 : bit_count + 35'h1;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            dispatch_pending <= 1'b0;
            local_pending <= 1'b0;
            relay_pending <= 1'b0;
            tx_start <= 1'b0;
            tx_from_relay <= 1'b0;
            tx_busy <= 1'b0;
        end
        else
        begin
            tx_start <= 1'b0;
            if (!dispatch_active)
                dispatch_pending <= 1'b0;
            else if (dispatch_due)
                dispatch_pending <= 1'b1;
            if (local_request)
                local_pending <= 1'b1;
            if (relay_request)
                relay_pending <= 1'b1;
            if (!tx_busy &&
                (relay_pending || local_pending || (dispatch_pending && dispatch_active)))
            begin
                tx_start <= 1'b1;
                tx_busy <= 1'b1;
                tx_from_relay <= relay_pending;
                if (relay_pending)
                    relay_pending <= relay_request;
                else if (local_pending)
                    local_pending <= local_request;
                else
                    dispatch_pending <= dispatch_due;
            end
            else if (tx_busy && (tx_done || tx_error))
                tx_busy <= 1'b0;
        end
    end

    start_single_a: assert property (@(posedge clock) disable iff (rst)
        tx_start |=> !tx_start) else $error("Back to back start.");
    no_dispatch_zero_a: assert property (@(posedge clock) disable iff (rst)
        !dispatch_active |-> ##1 !dispatch_pending) else $error("Dispatch while zero.");
    flag_needs_hit_a: assert property (@(posedge clock) disable iff (rst)
        rx_valid |=> relay_flag == ($past(hit) && $past(relay_enable)) &&
        accepted == $past(hit))
        else $error("Relay flag mismatch.");
    busy_after_start_a: assert property (@(posedge clock) disable iff (rst)
        tx_busy && !tx_done && !tx_error |=> tx_busy) else $error("Busy dropped early.");
    error_release_a: assert property (@(posedge clock) disable iff (rst)
        tx_busy && !tx_start && tx_error |=> !tx_busy) else $error("Busy after error.");
    dispatch_start_c: cover property (@(posedge clock) dispatch_pending ##[1:3] tx_start);
    relay_start_c: cover property (@(posedge clock) tx_start && tx_from_relay);
endmodule : can_ext_channel
`default_nettype wire

//--- can_dispatch_forward_loopback.sv
// Purpose: Dispatch, relay and loop test extensions around two CAN controllers.
// Assumes: An 8-bit register port; each controller gives its own bit tick.
// Notes: Controller 1 registers sit at the same offsets plus CTRL1_DELTA.
// Overview of operation
// - Send buffer every hundred times A bits
// - Interval zero disables dispatch
// - Dispatch bus error: no retry
// - Relay-enabled filter hit sets relay flag
// - Relay request: other controller sends receive buffer
// - Relay works in both directions
// - Each controller keeps its own bit rate
// - Loop tests run internally without transceiver
// - Self loop hears only own transmission
// - Dual loop joins controllers, ignores buses
// - Accept when unmasked identifier bits match
`timescale 1ns/1ps
`default_nettype none
module can_dispatch_forward_loopback
(
    input wire logic clock,
    input wire logic rst,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [1:0] bit_tick,
    input wire logic [1:0] engine_tx_bit,
    input wire logic [1:0] bus_rx_pin,
    input wire logic [1:0] rx_valid,
    input wire can_ext_pkg::rx_frame_t rx_frame0,
    input wire can_ext_pkg::rx_frame_t rx_frame1,
    input wire logic [1:0] tx_done,
    input wire logic [1:0] tx_error,
    output logic [7:0] reg_rdata,
    output logic [1:0] engine_rx_bit,
    output logic [1:0] bus_tx_pin,
    output logic [1:0] tx_start,
    output logic [1:0] tx_from_relay,
    output logic [1:0] relay_flag
);
    logic [7:0] regs [2][16];
    logic [1:0] cmd_local;
    logic [1:0] cmd_relay;
    logic [1:0] dispatch_written;
    logic [1:0] accepted;
    logic [1:0] busy;
    logic [1:0] start_w;
    logic [1:0] from_relay_w;
    logic [1:0] flag_w;
    logic [1:0] next_rx_bit;
    logic self_loop [2];
    logic dual_loop;
    logic [3:0] slot;
    logic sel;

    function automatic logic [3:0] slot_of(input logic [11:0] off);
        logic [3:0] s;
        s = 4'hF;
        unique case (off)
            can_ext_pkg::FILTER0_MATCH_BYTE3: s = 4'h0;
            can_ext_pkg::FILTER0_IGNORE_BYTE3: s = 4'h1;
            can_ext_pkg::FILTER0_MATCH_BYTE2: s = 4'h2;
            can_ext_pkg::FILTER0_IGNORE_BYTE2: s = 4'h3;
            can_ext_pkg::FILTER0_MATCH_BYTE1: s = 4'h4;
            can_ext_pkg::FILTER0_IGNORE_BYTE1: s = 4'h5;
            can_ext_pkg::FILTER0_MATCH_BYTE0: s = 4'h6;
            can_ext_pkg::FILTER0_IGNORE_BYTE0: s = 4'h7;
            can_ext_pkg::RELAY_ENABLE_REG: s = 4'h8;
            can_ext_pkg::TEST_MODE_REG: s = 4'h9;
            can_ext_pkg::DISPATCH_BYTE0: s = 4'hA;
            can_ext_pkg::DISPATCH_BYTE1: s = 4'hB;
            can_ext_pkg::DISPATCH_BYTE2: s = 4'hC;
            can_ext_pkg::DISPATCH_BYTE3: s = 4'hD;
            can_ext_pkg::STATUS_REG: s = 4'hE;
            default: s = 4'hF;
        endcase
        return s;
    endfunction : slot_of

    assign sel = reg_addr >=
        (can_ext_pkg::FILTER0_MATCH_BYTE3 + can_ext_pkg::CTRL1_DELTA - 12'h30);
    assign slot = slot_of(sel ? reg_addr - can_ext_pkg::CTRL1_DELTA : reg_addr);
    // Dual loop is taken from controller 0's test register only, so both ends agree.
    assign dual_loop = regs[0][9][can_ext_pkg::TEST_DUAL_LOOP_BIT];

    // Storage writes; status and command slots are not stored.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            for (int c = 0; c < 2; c++)
                for (int i = 0; i < 16; i++)
                    regs[c][i] <= can_ext_pkg::BYTE_RESET;
        end
        else if (reg_write && slot < 4'hE)
            regs[sel][slot] <= reg_wdata;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_read)
            reg_rdata <= (slot == 4'hE) ? {4'h0, busy, accepted[sel], flag_w[sel]} :
                         (slot == 4'hF) ? 8'h00 : regs[sel][slot];
    end

    generate
        for (genvar c = 0; c < 2; c++)
        begin : chan
            logic wr_cmd;
            assign wr_cmd = reg_write && (sel == 1'(c)) && (slot_of(reg_addr -
                (c == 1 ? can_ext_pkg::CTRL1_DELTA : 12'h000)) == 4'hF) &&
                (reg_addr - (c == 1 ? can_ext_pkg::CTRL1_DELTA : 12'h000)
                == can_ext_pkg::COMMAND_REG);
            assign cmd_local[c] = wr_cmd && reg_wdata[can_ext_pkg::CMD_TX_REQUEST_BIT];
            assign cmd_relay[c] = wr_cmd && reg_wdata[can_ext_pkg::CMD_RELAY_REQUEST_BIT];
            assign dispatch_written[c] = reg_write && (sel == 1'(c)) &&
                slot >= 4'hA && slot <= 4'hD;
            assign self_loop[c] = regs[c][9][can_ext_pkg::TEST_SELF_LOOP_BIT];

            // relay request of one side drives the other
            can_ext_channel channel (
                .clock(clock),
                .rst(rst),
                .bit_tick(bit_tick[c]),
                .match_code({regs[c][0], regs[c][2], regs[c][4], regs[c][6]}),
                .ignore_code({regs[c][1], regs[c][3], regs[c][5], regs[c][7]}),
                .relay_enable(regs[c][8][0]),
                .dispatch_value({regs[c][13][3:0], regs[c][12], regs[c][11], regs[c][10]}),
                .dispatch_written(dispatch_written[c]),
                .rx_valid(rx_valid[c]),
                .rx_ident(c == 0 ? rx_frame0.ident : rx_frame1.ident),
                .rx_extended(c == 0 ? rx_frame0.extended : rx_frame1.extended),
                .local_request(cmd_local[c]),
                .relay_request(cmd_relay[1 - c]),
                .tx_done(tx_done[c]),
                .tx_error(tx_error[c]),
                .accepted(accepted[c]),
                .relay_flag(flag_w[c]),
                .tx_start(start_w[c]),
                .tx_from_relay(from_relay_w[c]),
                .tx_busy(busy[c])
            );

            always_comb
            begin
                if (dual_loop)
                    next_rx_bit[c] = engine_tx_bit[0] & engine_tx_bit[1];
                else if (self_loop[c])
                    next_rx_bit[c] = engine_tx_bit[c];
                else
                    next_rx_bit[c] = bus_rx_pin[c];
            end

            always_ff @(posedge clock)
            begin
                if (rst)
                begin
                    engine_rx_bit[c] <= 1'b1;
                    bus_tx_pin[c] <= 1'b1;
                end
                else
                begin
                    engine_rx_bit[c] <= next_rx_bit[c];
                    // Loop tests keep the bus recessive so online testing disturbs nobody.
                    bus_tx_pin[c] <= (dual_loop || self_loop[c]) ? 1'b1 : engine_tx_bit[c];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            tx_start <= 2'b00;
            tx_from_relay <= 2'b00;
            relay_flag <= 2'b00;
        end
        else
        begin
            tx_start <= start_w;
            tx_from_relay <= from_relay_w;
            relay_flag <= flag_w;
        end
    end

    self_loop_isolated_a: assert property (@(posedge clock) disable iff (rst)
        self_loop[0] && !dual_loop |=> engine_rx_bit[0] == $past(engine_tx_bit[0]))
        else $error("Self loop heard bus.");
    dual_loop_joined_a: assert property (@(posedge clock) disable iff (rst)
        dual_loop |=> engine_rx_bit[1] == ($past(engine_tx_bit[0]) & $past(engine_tx_bit[1])))
        else $error("Dual loop path broken.");
    loop_bus_quiet_a: assert property (@(posedge clock) disable iff (rst)
        dual_loop |=> bus_tx_pin == 2'b11) else $error("Bus driven in loop test.");
    self_loop_quiet_a: assert property (@(posedge clock) disable iff (rst)
        self_loop[1] |=> bus_tx_pin[1]) else $error("Bus driven in self loop.");
    relay_cross_a: assert property (@(posedge clock) disable iff (rst)
        cmd_relay[0] && !busy[1] |-> ##[1:3] tx_start[1] && tx_from_relay[1])
        else $error("Relay not started.");
    relay_back_a: assert property (@(posedge clock) disable iff (rst)
        cmd_relay[1] && !busy[0] |-> ##[1:3] tx_start[0] && tx_from_relay[0])
        else $error("Reverse relay not started.");
    dual_loop_c: cover property (@(posedge clock) dual_loop ##1 tx_start[0]);
    self_loop_c: cover property (@(posedge clock) self_loop[1] && tx_start[1]);
endmodule : can_dispatch_forward_loopback
`default_nettype wire

//--- can_net_model.sv
// Purpose: Far side of both channels: protocol engines and CAN networks.
// Assumes: A started frame ends LAT cycles later, with an error where err_mode asks.
// Notes: Receive lines come from an LFSR stepped every cycle, so a loop test cannot pass on stale bus data.
`timescale 1ns/1ps
`default_nettype none
module can_net_model
#(
    parameter int LAT = 20
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [1:0] tx_start,
    input wire logic [1:0] err_mode,
    output logic [1:0] tx_done,
    output logic [1:0] tx_error,
    output logic [1:0] bus_rx_pin
);
    int cnt [2];
    logic [7:0] lfsr = 8'hA5;
    assign tx_done = {cnt[1] == 1 && !err_mode[1], cnt[0] == 1 && !err_mode[0]};
    assign tx_error = {cnt[1] == 1 && err_mode[1], cnt[0] == 1 && err_mode[0]};
    assign bus_rx_pin = lfsr[1:0];
    always @(posedge clock)
    begin
        lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        for (int i = 0; i < 2; i++)
        begin
            if (rst)
                cnt[i] <= 0;
            else if (tx_start[i])
                cnt[i] <= LAT;
            else if (cnt[i] != 0)
                cnt[i] <= cnt[i] - 1;
        end
    end
endmodule : can_net_model
`default_nettype wire

//--- can_dispatch_forward_loopback_bench.sv
// Purpose: Self-checking bench for the dispatch, relay and loop test extensions.
// Assumes: Channel 0 ticks every 4 cycles and channel 1 every 3, so rates differ.
// Notes: Expectations come from bench functions, except the no-start checks, which compare against an earlier count of design starts.
`timescale 1ns/1ps
`default_nettype none
module can_dispatch_forward_loopback_bench;
    localparam int LAT = 20;
    localparam int MULT = can_ext_pkg::DISPATCH_BIT_MULT;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic [1:0] bit_tick = 2'h0;
    logic [1:0] engine_tx_bit = 2'h3;
    logic [1:0] rx_valid = 2'h0;
    logic [1:0] err_mode = 2'h0;
    can_ext_pkg::rx_frame_t fr = '0;
    logic [1:0] bus_rx_pin, tx_done, tx_error, engine_rx_bit, bus_tx_pin;
    logic [1:0] tx_start, tx_from_relay, relay_flag, rel;
    logic [7:0] reg_rdata;
    logic [31:0] seed = 32'h28;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    int tk [2], ns [2], st_tk [2], st_cyc [2];
    can_dispatch_forward_loopback dut (.clock(clock), .rst(rst), .reg_write(reg_write),
        .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .bit_tick(bit_tick),
        .engine_tx_bit(engine_tx_bit), .bus_rx_pin(bus_rx_pin), .rx_valid(rx_valid),
        .rx_frame0(fr), .rx_frame1(fr), .tx_done(tx_done), .tx_error(tx_error),
        .reg_rdata(reg_rdata), .engine_rx_bit(engine_rx_bit), .bus_tx_pin(bus_tx_pin),
        .tx_start(tx_start), .tx_from_relay(tx_from_relay), .relay_flag(relay_flag));
    can_net_model #(.LAT(LAT)) net (.clock(clock), .rst(rst), .tx_start(tx_start),
        .err_mode(err_mode), .tx_done(tx_done), .tx_error(tx_error), .bus_rx_pin(bus_rx_pin));
    initial
        forever #2.5 clock = ~clock;
    always @(posedge clock)
        #1 bit_tick = {cyc % 3 == 0, cyc % 4 == 0};
    // Starts are stamped in both ticks and cycles for period and spacing checks.
    always @(posedge clock)
    begin
        cyc++;
        for (int i = 0; i < 2; i++)
        begin
            if (bit_tick[i] === 1'b1)
                tk[i]++;
            if (tx_start[i] === 1'b1)
            begin
                ns[i]++;
                st_tk[i] = tk[i];
                st_cyc[i] = cyc;
                rel[i] = tx_from_relay[i];
            end
        end
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic logic hit(input logic [28:0] i, input logic e, input logic [31:0] m, g);
        logic [31:0] v;
        v = e ? {3'h0, i} : {21'h0, i[10:0]};
        return ((v ^ m) & ~g) == 32'h0;
    endfunction : hit
    function automatic logic [11:0] ad(input int c, input logic [11:0] a);
        return a + (c != 0 ? can_ext_pkg::CTRL1_DELTA : 12'h000);
    endfunction : ad
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clock);
        #1;
        reg_write = 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clock);
        #1;
        reg_read = 1'b1;
        reg_addr = a;
        @(posedge clock);
        #1;
        reg_read = 1'b0;
        d = reg_rdata;
    endtask : rd
    task automatic dsp(input int c, input logic [7:0] v);
        wr(ad(c, can_ext_pkg::DISPATCH_BYTE3), 8'h00);
        wr(ad(c, can_ext_pkg::DISPATCH_BYTE2), 8'h00);
        wr(ad(c, can_ext_pkg::DISPATCH_BYTE1), 8'h00);
        wr(ad(c, can_ext_pkg::DISPATCH_BYTE0), v);
    endtask : dsp
    // A hang is reported as a mismatch and ends the run.
    task automatic wait_start(input int i, input int n0, input int lim);
        int k;
        k = 0;
        while (ns[i] <= n0 && k < lim)
        begin
            @(posedge clock);
            #1;
            k++;
        end
        if (ns[i] <= n0)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t no frame start", $time);
            end_sim();
        end
    endtask : wait_start
    initial
    begin
        logic [7:0] d;
        logic [31:0] m, g, id;
        logic [1:0] pe, pb;
        logic en, h;
        int c, a, a0, t0;
        repeat (3) @(posedge clock);
        #1;
        rst = 1'b0;
        for (int j = 0; j < 8; j++)
        begin
            rd(12'hB28 + 12'(j), d);
            chk(d, can_ext_pkg::BYTE_RESET);
        end
        wr(12'h000, 8'h5A);
        rd(12'h000, d);
        chk(d, 8'h00);
        for (int t = 0; t < 16; t++)
        begin
            c = t % 2;
            m = xs();
            id = xs();
            g = (t < 2 ? 32'h0 : id & xs()) | 32'hE0000000;
            id = m ^ (t < 2 ? 32'h0 : xs() & xs() & xs());
            fr.extended = t < 2 || id[31];
            fr.ident = id[28:0];
            en = t < 2 || id[30];
            h = hit(fr.ident, fr.extended, m, g);
            for (int j = 0; j < 4; j++)
            begin
                wr(ad(c, 12'hB28 + 12'(2 * j)), m[31 - 8 * j -: 8]);
                wr(ad(c, 12'hB29 + 12'(2 * j)), g[31 - 8 * j -: 8]);
            end
            wr(ad(c, can_ext_pkg::RELAY_ENABLE_REG), {7'h00, en});
            rd(ad(c, can_ext_pkg::FILTER0_MATCH_BYTE0), d);
            chk(d, m[7:0]);
            rx_valid[c] = 1'b1;
            @(posedge clock);
            #1;
            rx_valid[c] = 1'b0;
            repeat (2) @(posedge clock);
            #1;
            chk(relay_flag[c], h & en);
            rd(ad(c, can_ext_pkg::STATUS_REG), d);
            chk(d[1:0], {h, h & en});
        end
        for (c = 0; c < 2; c++)
        begin
            a = ns[1 - c];
            a0 = ns[c];
            wr(ad(c, can_ext_pkg::COMMAND_REG), 8'h01 << can_ext_pkg::CMD_RELAY_REQUEST_BIT);
            wait_start(1 - c, a, 10);
            chk(rel[1 - c], 1'b1);
            chk(ns[c], a0);
            repeat (LAT + 5) @(posedge clock);
        end
        a = ns[1];
        wr(ad(1, can_ext_pkg::COMMAND_REG), 8'h01 << can_ext_pkg::CMD_TX_REQUEST_BIT);
        wr(ad(0, can_ext_pkg::COMMAND_REG), 8'h01 << can_ext_pkg::CMD_RELAY_REQUEST_BIT);
        wait_start(1, a, 10);
        chk(rel[1], 1'b0);
        t0 = st_cyc[1];
        wait_start(1, a + 1, LAT + 20);
        chk(rel[1], 1'b1);
        chk(st_cyc[1] - t0 >= LAT, 1'b1);
        repeat (LAT + 5) @(posedge clock);
        for (int k = 0; k < 3; k++)
        begin
            c = k % 2;
            a = (k == 2) ? 2 + int'(xs() % 2) : 1;
            err_mode[c] = k == 2;
            dsp(c, 8'(a));
            t0 = tk[c];
            a0 = ns[c];
            wait_start(c, a0, 500 * a + 50);
            chk(st_tk[c] - t0 >= MULT * a - 1 && st_tk[c] - t0 <= MULT * a + 1, 1'b1);
            t0 = st_tk[c];
            wait_start(c, a0 + 1, 500 * a + 50);
            chk(st_tk[c] - t0, MULT * a);
            dsp(c, 8'h00);
            a0 = ns[c];
            repeat (1300) @(posedge clock);
            chk(ns[c], a0);
            err_mode[c] = 1'b0;
        end
        for (int md = 0; md < 3; md++)
        begin
            wr(ad(0, can_ext_pkg::TEST_MODE_REG),
                md == 2 ? 8'h01 << can_ext_pkg::TEST_DUAL_LOOP_BIT :
                8'(md) << can_ext_pkg::TEST_SELF_LOOP_BIT);
            wr(ad(1, can_ext_pkg::TEST_MODE_REG), {7'h00, md == 1});
            pe = engine_tx_bit;
            pb = bus_rx_pin;
            repeat (24)
            begin
                @(posedge clock);
                #1;
                chk(engine_rx_bit, md == 0 ? pb : md == 1 ? pe : {2{&pe}});
                chk(bus_tx_pin, md == 0 ? pe : 2'h3);
                id = xs();
                engine_tx_bit = id[1:0];
                pe = id[1:0];
                pb = bus_rx_pin;
            end
        end
        end_sim();
    end
endmodule : can_dispatch_forward_loopback_bench
`default_nettype wire
